// ==== pkg/charger_regs.vh ====
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 40 MHz clock, APB with 32-bit data
// Notes:   Definitions only
`ifndef CHARGER_REGS_VH
`define CHARGER_REGS_VH

`define CTRL_OFS          12'h000
`define SETTING_OFS       12'h004
`define STATUS_OFS        12'h008
`define EVENT_OFS         12'h00C
`define LEVEL_OFS         12'h010
`define WDOG_OFS          12'h014

// Control field positions
`define CTRL_CHG_EN       0
`define CTRL_PQ_EN        1
`define CTRL_WD_EN        2
`define CTRL_RESET        32'h0000_0003

// Setting register: fast-charge current [7:0], input current limit [14:8]
`define SETTING_RESET     32'h0000_7F20

// Detail codes
`define DTL_PRECHG        4'h0
`define DTL_FASTCC        4'h1
`define DTL_FASTCV        4'h2
`define DTL_TFAULT        4'h6
`define DTL_WDSUSP        4'hB
`define DTL_IDLE          4'h8

// Currents in setting units (arbitrary scale)
`define PRECHARGE_CURRENT 8'h04
`define TRICKLE_CURRENT   8'h0A
`define FOLDBACK_STEP     8'h08

// Qualification delay, 128 us at 25 ns per cycle
`define QUAL_DELAY_CYC    16'h1400
// Safety timer prescaler tick
`define TIMER_PRESCALE    16'h9C40
`endif

// ==== logic/battery_charge_state_machine.v ====
// Purpose: Charger sequencer with APB registers
// Assumes: Comparator inputs are asynchronous pins; 40 MHz clock
// Notes:   Analog loops, top-off, done and thermal shutdown are outside
//
// What this block does
// - Charger off or bad input forces idle from every state.
// - Idle after qualify delay: code 0x08, good flag set, irq if it was clear.
// - Idle commands zero current and holds watchdog and safety timers at zero.
// - Leave idle only with valid input and charging enabled together.
// - Battery below precharge threshold: precharge current; qualified code 0x00 and flag.
// - Battery above precharge threshold moves precharge to trickle.
// - Precharge or trickle beyond prequal timeout goes to timer fault.
// - Enabled watchdog expiry in precharge, trickle or fast CC goes to suspend.
// - Trickle with prequal enabled limits current to trickle level; code 0x00.
// - Prequal disabled skips trickle into fast charge at fast-charge current.
// - Trickle exits to fast CC above minsys less 500mV or prequal cleared.
// - Fast CC between thresholds; qualified code 0x01, flag, irq if clear.
// - Fast CC caps current, reduced for limit, low input, foldback, load.
// - Battery above regulation voltage moves fast CC to constant voltage.
// - Fast CC beyond fast-charge timeout goes to timer fault.
// - Die above foldback temperature in fast charge reduces fast-charge current.
// - Input current at 50mA cutoff with voltage still low switches input off.
// - Input regulation active raises input-limit event and clears inactive bit.
// - Limited input power serves system load first, battery gets the rest.
// - Constant voltage after qualify delay: code 0x02, flag, irq if clear.
// - Timer fault entry: immediate irq, flag cleared, code 0x06.
`timescale 1ns/1ps
`include "charger_regs.vh"

module battery_charge_state_machine (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Analog comparator pins
  input  wire        input_supply_valid,
  input  wire        batt_above_precharge,
  input  wire        batt_above_sysmin,
  input  wire        batt_above_regulation,
  input  wire        die_above_foldback,
  input  wire        input_reg_active,
  input  wire        input_at_cutoff,
  input  wire        input_current_limited,
  input  wire        system_load_demand,
  input  wire [7:0]  system_load_current,
  // Outputs to power stage and host
  output reg  [7:0]  charge_current_cmd,
  output reg         input_switch_on,
  output reg         charge_event_irq,
  output reg         input_limit_event,
  output reg  [3:0]  charge_detail_code,
  output reg         charge_good_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Suspend has a bit of its own, so no state can be mistaken for all zeros
  localparam [6:0] ST_IDLE   = 7'b0000001;
  localparam [6:0] ST_PRECHG = 7'b0000010;
  localparam [6:0] ST_TRICK  = 7'b0000100;
  localparam [6:0] ST_FASTCC = 7'b0001000;
  localparam [6:0] ST_FASTCV = 7'b0010000;
  localparam [6:0] ST_FAULT  = 7'b0100000;
  localparam [6:0] ST_WDSUSP = 7'b1000000;

  localparam [15:0] QUAL_CYC = `QUAL_DELAY_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for all comparator pins
  // Each pin is a slow analog level, so two flops settle it before use
  reg [8:0] pin_meta_reg;
  reg [8:0] pin_sync_reg;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= 9'h000;
      pin_sync_reg <= 9'h000;
    end else begin
      pin_meta_reg <= {input_current_limited, system_load_demand, input_at_cutoff,
                       input_reg_active, die_above_foldback, batt_above_regulation,
                       batt_above_sysmin, batt_above_precharge, input_supply_valid};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  wire in_valid   = pin_sync_reg[0];
  wire above_pre  = pin_sync_reg[1];
  wire above_sys  = pin_sync_reg[2];
  wire above_reg  = pin_sync_reg[3];
  wire hot        = pin_sync_reg[4];
  wire reg_active = pin_sync_reg[5];
  wire at_cutoff  = pin_sync_reg[6];
  wire load_dem   = pin_sync_reg[7];
  wire in_limited = pin_sync_reg[8];

  reg [7:0] load_meta_reg;
  reg [7:0] load_sync_reg;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      load_meta_reg <= 8'h00;
      load_sync_reg <= 8'h00;
    end else begin
      load_meta_reg <= system_load_current;
      load_sync_reg <= load_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [31:0] ctrl_reg;
  reg [31:0] setting_reg;
  reg [15:0] prequal_limit_reg;
  reg [15:0] fast_limit_reg;
  reg [15:0] wdog_limit_reg;
  reg        wdog_kick;
  reg        input_limit_inactive;

  wire chg_en    = ctrl_reg[`CTRL_CHG_EN];
  wire prequal_enable = ctrl_reg[`CTRL_PQ_EN];
  wire wd_en     = ctrl_reg[`CTRL_WD_EN];
  wire [7:0] fast_charge_current = setting_reg[7:0];

  wire apb_access = psel && penable;
  wire apb_wr     = apb_access && pwrite;

  reg [6:0]  state_reg;
  reg [6:0]  state_next;
  reg [15:0] qual_cnt_reg;
  reg [15:0] pre_cnt_reg;
  reg [15:0] safety_cnt_reg;
  reg [15:0] wdog_cnt_reg;
  reg        event_sticky_reg;
  reg        limit_sticky_reg;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg          <= `CTRL_RESET;
      setting_reg       <= `SETTING_RESET;
      prequal_limit_reg <= 16'h0100;
      fast_limit_reg    <= 16'h1000;
      wdog_limit_reg    <= 16'h0100;
      wdog_kick         <= 1'b0;
    end else begin
      wdog_kick <= 1'b0;
      if (apb_wr) begin
        case (paddr)
          `CTRL_OFS:    ctrl_reg <= {29'h0, pwdata[2:0]};
          `SETTING_OFS: setting_reg <= {17'h0, pwdata[14:0]};
          `LEVEL_OFS: begin
            prequal_limit_reg <= pwdata[15:0];
            fast_limit_reg    <= pwdata[31:16];
          end
          `WDOG_OFS: begin
            wdog_limit_reg <= pwdata[15:0];
            wdog_kick      <= pwdata[16];
          end
          default: ;
        endcase
      end
    end
  end

  // Reading the event register clears the sticky copies; a new event wins.
  // The clear comes in the setup cycle, where the read data is latched, so an
  // event that lands between setup and access is not lost.
  wire ev_read = psel && !penable && !pwrite && (paddr == `EVENT_OFS);

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `CTRL_OFS:    prdata <= ctrl_reg;
          `SETTING_OFS: prdata <= setting_reg;
          `STATUS_OFS:  prdata <= {19'h0, state_reg, input_limit_inactive,
                                   charge_good_flag, charge_detail_code};
          `EVENT_OFS:   prdata <= {30'h0, limit_sticky_reg, event_sticky_reg};
          `LEVEL_OFS:   prdata <= {fast_limit_reg, prequal_limit_reg};
          `WDOG_OFS:    prdata <= {16'h0, wdog_limit_reg};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State sequencing
  // One free-running prescaler serves every safety timer, so a timeout may end
  // up to one tick early; a divider per timer was not worth the flops.
  wire prescale_tick;
  reg [15:0] prescale_reg;
  assign prescale_tick = (prescale_reg == `TIMER_PRESCALE - 16'h0001);
  wire wd_expired = wd_en && (wdog_cnt_reg >= wdog_limit_reg);
  wire state_change = (state_next != state_reg);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (in_valid && chg_en) begin
          if (!above_pre)
            state_next = ST_PRECHG;
          else if (above_sys || !prequal_enable)
            state_next = above_reg ? ST_FASTCV : ST_FASTCC;
          else
            state_next = ST_TRICK;
        end
      end
      ST_PRECHG: begin
        if (wd_expired)
          state_next = ST_WDSUSP;
        else if (pre_cnt_reg >= prequal_limit_reg)
          state_next = ST_FAULT;
        else if (above_pre)
          state_next = prequal_enable ? ST_TRICK : ST_FASTCC;
      end
      ST_TRICK: begin
        if (wd_expired)
          state_next = ST_WDSUSP;
        else if (pre_cnt_reg >= prequal_limit_reg)
          state_next = ST_FAULT;
        else if (above_sys || !prequal_enable)
          state_next = ST_FASTCC;
      end
      ST_FASTCC: begin
        if (wd_expired)
          state_next = ST_WDSUSP;
        else if (safety_cnt_reg >= fast_limit_reg)
          state_next = ST_FAULT;
        else if (above_reg)
          state_next = ST_FASTCV;
      end
      ST_FASTCV: begin
        if (safety_cnt_reg >= fast_limit_reg)
          state_next = ST_FAULT;
      end
      ST_FAULT: ;
      ST_WDSUSP: begin
        if (wdog_kick)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (!in_valid || !chg_en)
      state_next = ST_IDLE;
  end

  // The counter parks at its end, so reporting stays armed while the state holds
  wire qual_done = (qual_cnt_reg == QUAL_CYC - 16'h0001);
  reg  [3:0] code_now;
  always @* begin
    case (state_reg)
      ST_PRECHG: code_now = `DTL_PRECHG;
      ST_TRICK:  code_now = `DTL_PRECHG;
      ST_FASTCC: code_now = `DTL_FASTCC;
      ST_FASTCV: code_now = `DTL_FASTCV;
      default:   code_now = `DTL_IDLE;
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg          <= ST_IDLE;
      qual_cnt_reg       <= 16'h0000;
      prescale_reg       <= 16'h0000;
      pre_cnt_reg        <= 16'h0000;
      safety_cnt_reg     <= 16'h0000;
      wdog_cnt_reg       <= 16'h0000;
      charge_detail_code <= `DTL_IDLE;
      charge_good_flag   <= 1'b0;
      charge_event_irq   <= 1'b0;
    end else begin
      state_reg        <= state_next;
      charge_event_irq <= 1'b0;
      prescale_reg     <= prescale_tick ? 16'h0000 : prescale_reg + 16'h0001;
      if (state_change)
        qual_cnt_reg <= 16'h0000;
      else if (!qual_done)
        qual_cnt_reg <= qual_cnt_reg + 16'h0001;
      if (state_reg == ST_IDLE) begin
        pre_cnt_reg    <= 16'h0000;
        safety_cnt_reg <= 16'h0000;
        wdog_cnt_reg   <= 16'h0000;
      end else begin
        if (state_next == ST_FASTCC && state_reg != ST_FASTCC && state_reg != ST_FASTCV)
          safety_cnt_reg <= 16'h0000;
        else if (prescale_tick && (state_reg == ST_FASTCC || state_reg == ST_FASTCV))
          safety_cnt_reg <= safety_cnt_reg + 16'h0001;
        if (prescale_tick && (state_reg == ST_PRECHG || state_reg == ST_TRICK))
          pre_cnt_reg <= pre_cnt_reg + 16'h0001;
        if (wdog_kick || !wd_en)
          wdog_cnt_reg <= 16'h0000;
        else if (prescale_tick && !wd_expired)
          wdog_cnt_reg <= wdog_cnt_reg + 16'h0001;
      end
      if (state_change && state_next == ST_FAULT) begin
        charge_event_irq   <= 1'b1;
        charge_good_flag   <= 1'b0;
        charge_detail_code <= `DTL_TFAULT;
      end else if (state_change && state_next == ST_WDSUSP) begin
        charge_event_irq   <= charge_good_flag;
        charge_good_flag   <= 1'b0;
        charge_detail_code <= `DTL_WDSUSP;
      end else if (qual_done && !state_change && state_reg != ST_FAULT
                   && state_reg != ST_WDSUSP && code_now != charge_detail_code) begin
        charge_detail_code <= code_now;
        charge_good_flag   <= 1'b1;
        charge_event_irq   <= !charge_good_flag;
      end else if (qual_done && !charge_good_flag && state_reg != ST_FAULT
                   && state_reg != ST_WDSUSP) begin
        charge_good_flag   <= 1'b1;
        charge_event_irq   <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current command and input regulation
  reg [7:0] base_cur;
  reg [7:0] avail_cur;
  always @* begin
    case (state_reg)
      ST_PRECHG: base_cur = `PRECHARGE_CURRENT;
      ST_TRICK:  base_cur = `TRICKLE_CURRENT;
      ST_FASTCC: base_cur = fast_charge_current;
      ST_FASTCV: base_cur = fast_charge_current;
      default:   base_cur = 8'h00;
    endcase
    if (hot && (state_reg == ST_FASTCC || state_reg == ST_FASTCV))
      base_cur = (base_cur > `FOLDBACK_STEP) ? base_cur - `FOLDBACK_STEP : 8'h00;
    if (in_limited || reg_active)
      base_cur = {1'b0, base_cur[7:1]};
    // Load is served first from the input; the battery gets what is left
    avail_cur = {1'b0, setting_reg[14:8]};
    if (load_dem)
      avail_cur = (avail_cur > load_sync_reg) ? avail_cur - load_sync_reg : 8'h00;
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      charge_current_cmd   <= 8'h00;
      input_switch_on      <= 1'b0;
      input_limit_event    <= 1'b0;
      input_limit_inactive <= 1'b1;
      event_sticky_reg     <= 1'b0;
      limit_sticky_reg     <= 1'b0;
    end else begin
      charge_current_cmd <= (base_cur < avail_cur) ? base_cur : avail_cur;
      input_switch_on    <= in_valid && !(reg_active && at_cutoff);
      input_limit_event  <= reg_active && input_limit_inactive;
      input_limit_inactive <= !reg_active;
      event_sticky_reg   <= charge_event_irq | (event_sticky_reg & !ev_read);
      limit_sticky_reg   <= input_limit_event | (limit_sticky_reg & !ev_read);
    end
  end

endmodule

// ==== verification/charger_asserts.sv ====
// Purpose: Port-level assertions for the charger sequencer
// Assumes: Inputs pass a 2-flop sync before use
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
module charger_asserts (
  // Clock and reset
  input logic       clock,
  input logic       rstn,
  // Bus handshake
  input logic       psel,
  input logic       penable,
  input logic       pready,
  // Analog status
  input logic       input_supply_valid,
  input logic       input_reg_active,
  input logic       input_at_cutoff,
  // Outputs watched
  input logic [7:0] charge_current_cmd,
  input logic       input_switch_on,
  input logic       charge_event_irq,
  input logic       input_limit_event,
  input logic [3:0] charge_detail_code,
  input logic       charge_good_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  // Cycles since the detail code last moved; saturates so it never wraps
  reg [13:0] gap_cnt;
  reg [3:0]  code_prev_reg;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap_cnt <= 14'h0000;
      code_prev_reg <= 4'h8;
    end else begin
      code_prev_reg <= charge_detail_code;
      if (charge_detail_code != code_prev_reg)
        gap_cnt <= 14'h0000;
      else if (gap_cnt != 14'h3FFF)
        gap_cnt <= gap_cnt + 14'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_IDLE_ZERO: assert property (
    !input_supply_valid [*6] |-> charge_current_cmd == 8'h00) else $error("current while idle");
  AST_GOOD_IRQ: assert property (
    $rose(charge_good_flag) |-> charge_event_irq) else $error("good flag rose without irq");
  AST_IRQ_PULSE: assert property (
    charge_event_irq |=> !charge_event_irq) else $error("irq longer than one cycle");
  AST_FAULT: assert property (
    $rose(charge_detail_code == 4'h6) |-> charge_event_irq && !charge_good_flag)
    else $error("fault entry report wrong");
  AST_QUAL_GAP: assert property (
    $changed(charge_detail_code) && charge_detail_code != 4'h6 && charge_detail_code != 4'hB
    |-> gap_cnt >= 14'h1388) else $error("code changed before qualify delay");
  AST_EVT_RISE: assert property (
    $rose(input_reg_active) |-> ##[1:4] input_limit_event) else $error("no input limit event");
  AST_EVT_PULSE: assert property (
    input_limit_event |=> !input_limit_event) else $error("event longer than one cycle");
  AST_CUTOFF: assert property (
    (input_at_cutoff && input_reg_active) [*6] |-> !input_switch_on)
    else $error("input not switched off");
  AST_APB_ANSWER: assert property (
    psel && !penable |=> pready) else $error("no ready in first access cycle");
endmodule

// ==== verification/battery_model.sv ====
// Purpose: Cell voltage seen through the charger comparators
// Assumes: Stage 0 below precharge, 1 trickle, 2 fast, 3 above regulation
// Notes:   Voltage walks one stage per clock, never jumps
`timescale 1ns/1ps
module battery_model (
  // Clock and requested stage
  input  wire       clock,
  input  wire [1:0] stage,
  // Comparator levels
  output reg        batt_above_precharge,
  output reg        batt_above_sysmin,
  output reg        batt_above_regulation
);
  reg [1:0] level_reg;
  initial level_reg = 2'h0;
  always @(posedge clock) begin
    if (level_reg < stage)
      level_reg <= level_reg + 2'h1;
    else if (level_reg > stage)
      level_reg <= level_reg - 2'h1;
  end
  always @* begin
    batt_above_precharge = level_reg >= 2'h1;
    batt_above_sysmin = level_reg >= 2'h2;
    batt_above_regulation = level_reg == 2'h3;
  end
endmodule

// ==== verification/battery_charge_state_machine_tb.sv ====
// Purpose: Self-checking bench for the charger sequencer
// Assumes: Host side is this bench over APB
// Notes:   Timer fault wait spans up to one 1 ms tick
`timescale 1ns/1ps
`include "charger_regs.vh"
module battery_charge_state_machine_tb;
  reg clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rdat;
  reg        rerr, supply = 1'b0, fold = 1'b0, reg_act = 1'b0, cutoff = 1'b0, limited = 1'b0;
  reg        load = 1'b0;
  reg [7:0]  load_cur = 8'h00;
  reg [1:0]  stage = 2'h0;
  wire [31:0] prdata;
  wire pready, pslverr, b_pre, b_sys, b_reg, sw_on, irq, evt, good;
  wire [7:0] cur;
  wire [3:0] code;
  integer n_errors = 0, n_checks = 0, cycles = 0, irq_cnt = 0, evt_cnt = 0, i0;
  always #12.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////
  battery_model batt (.clock(clock), .stage(stage), .batt_above_precharge(b_pre),
    .batt_above_sysmin(b_sys), .batt_above_regulation(b_reg));
  battery_charge_state_machine dut (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .input_supply_valid(supply),
    .batt_above_precharge(b_pre), .batt_above_sysmin(b_sys), .batt_above_regulation(b_reg),
    .die_above_foldback(fold), .input_reg_active(reg_act), .input_at_cutoff(cutoff),
    .input_current_limited(limited), .system_load_demand(load),
    .system_load_current(load_cur), .charge_current_cmd(cur), .input_switch_on(sw_on),
    .charge_event_irq(irq), .input_limit_event(evt), .charge_detail_code(code),
    .charge_good_flag(good));
  ////////////////////////////////////////////////////////////////
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge clock); k = k + 1; end while (pready !== 1'b1);
      check(k < 20, 1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clock);
    end
  endtask
  task wait_code(input [3:0] c, input integer lim);
    integer k;
    begin
      k = 0;
      while (code !== c && k < lim) begin @(posedge clock); k = k + 1; end
      check(code, c);
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (evt === 1'b1) evt_cnt <= evt_cnt + 1;
    if (cycles == 60000) begin n_errors = n_errors + 1; finish_test; end
  end
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    check(code, `DTL_IDLE);
    apb(0, `CTRL_OFS, 0); check(rdat, `CTRL_RESET);
    apb(0, `SETTING_OFS, 0); check(rdat, `SETTING_RESET);
    apb(0, 12'h018, 0); check(rerr, 1); check(rdat, 0);
    $display("Test registers done");
    i0 = irq_cnt;
    while (good !== 1'b1 && cycles < 6000) @(posedge clock);
    @(posedge clock);
    check(good, 1);
    check(irq_cnt - i0, 1);
    check(cur, 0);
    $display("Test idle done");
    supply <= 1'b1; i0 = irq_cnt;
    repeat (10) @(posedge clock);
    check(code, `DTL_IDLE);
    check(cur, `PRECHARGE_CURRENT);
    wait_code(`DTL_PRECHG, 5300);
    check(irq_cnt, i0);
    stage <= 2'h1; repeat (8) @(posedge clock);
    check(cur, `TRICKLE_CURRENT);
    stage <= 2'h2; repeat (8) @(posedge clock);
    check(cur, 8'h20);
    wait_code(`DTL_FASTCC, 5300);
    fold <= 1'b1; repeat (8) @(posedge clock);
    check(cur, 8'h20 - `FOLDBACK_STEP);
    fold <= 1'b0; limited <= 1'b1; repeat (8) @(posedge clock);
    check(cur, 8'h10);
    limited <= 1'b0; load <= 1'b1; load_cur <= 8'h70; repeat (8) @(posedge clock);
    check(cur, 8'h0F);
    load <= 1'b0; stage <= 2'h3;
    wait_code(`DTL_FASTCV, 5300);
    $display("Test charge path done");
    apb(1, `CTRL_OFS, 2); stage <= 2'h1; repeat (4) @(posedge clock);
    check(cur, 0);
    wait_code(`DTL_IDLE, 5300);
    check(cur, 0);
    apb(1, `SETTING_OFS, 32'h0000_7F08);
    apb(1, `CTRL_OFS, 1); repeat (8) @(posedge clock);
    check(cur, 8'h08);
    wait_code(`DTL_FASTCC, 5300);
    apb(1, `SETTING_OFS, `SETTING_RESET); repeat (4) @(posedge clock);
    check(cur, 8'h20);
    $display("Test prequal off done");
    apb(1, `CTRL_OFS, 0); stage <= 2'h0;
    apb(1, `LEVEL_OFS, 32'h1000_0001); apb(1, `CTRL_OFS, 3);
    wait_code(`DTL_PRECHG, 5300);
    wait_code(`DTL_TFAULT, 90000);
    check(good, 0);
    supply <= 1'b0;
    wait_code(`DTL_IDLE, 5300);
    $display("Test timer fault done");
    supply <= 1'b1; i0 = evt_cnt; reg_act <= 1'b1; repeat (8) @(posedge clock);
    check(evt_cnt - i0, 1);
    apb(0, `STATUS_OFS, 0); check(rdat[5], 0);
    check(sw_on, 1);
    cutoff <= 1'b1; repeat (8) @(posedge clock);
    check(sw_on, 0);
    reg_act <= 1'b0; cutoff <= 1'b0; apb(1, `WDOG_OFS, 0); apb(1, `CTRL_OFS, 7);
    repeat (4) @(posedge clock);
    check(code, `DTL_WDSUSP);
    check(cur, 0);
    apb(1, `WDOG_OFS, 32'h0001_0100); repeat (8) @(posedge clock);
    check(cur, `PRECHARGE_CURRENT);
    apb(1, `SETTING_OFS, 32'h0000_0220);
    apb(0, `STATUS_OFS, 0); check(rdat[5], 1);
    check(cur, 8'h02);
    $display("Test input regulation done");
    finish_test;
  end
endmodule
bind battery_charge_state_machine charger_asserts u_chk (.clock, .rstn, .psel, .penable,
  .pready, .input_supply_valid, .input_reg_active, .input_at_cutoff, .charge_current_cmd,
  .input_switch_on, .charge_event_irq, .input_limit_event, .charge_detail_code,
  .charge_good_flag);
